// [sfw_pkg.sv]
// Constants shared by the sample queue watermark controller and its helpers.
package sfw_pkg;
  localparam int ITEM_W = 24;
  localparam int TAG_W = 5;
  localparam int VAL_W = 19;
  localparam int QUEUE_DEPTH = 128;
  localparam int IDX_W = 7;
  localparam int CNT_W = 8;
  localparam int THR_W = 7;
  localparam int STAGE_DEPTH = 16;
  localparam int TS_PERIOD = 8;
  localparam int PHASE_W = 3;

  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h03;
  localparam logic [7:0] ADDR_WR_IDX = 8'h04;
  localparam logic [7:0] ADDR_RD_IDX = 8'h05;
  localparam logic [7:0] ADDR_LOST = 8'h06;
  localparam logic [7:0] ADDR_COUNT = 8'h07;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_CFG1 = 8'h09;
  localparam logic [7:0] ADDR_CFG2 = 8'h0a;

  localparam int FLAG_AFULL_BIT = 7;
  localparam int FLAG_DRDY_BIT = 6;
  localparam int CFG2_TS_BIT = 5;
  localparam int CFG2_FLUSH_BIT = 4;
  localparam int CFG2_STATCLR_BIT = 3;
  localparam int CFG2_TYPE_BIT = 2;
  localparam int CFG2_OVERWRITE_BIT = 1;

  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [THR_W-1:0] THR_RST = 7'h00;
  localparam logic [IDX_W-1:0] LOST_MAX = 7'h7f;
  localparam logic [CNT_W-1:0] COUNT_FULL = 8'h80;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [TAG_W-1:0] TS_TAG = 5'h1e;
endpackage

// [sfw_stage_fifo.sv]
// Small staging FIFO with valid/ready on both sides and a synchronous clear.
module sfw_stage_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("Stage FIFO depth must be a power of two of at least 2.");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Ready and valid are kept as flops so the producer never sees a combinational path.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end
    else if (clear_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_out <= next_count != (AW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end
endmodule

// [sfw_flag_cell.sv]
// Sticky status flag in which a set always wins over a clear in the same cycle.
module sfw_flag_cell (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flag_out <= 1'b0;
    end
    else
    begin
      flag_out <= set_in || (flag_out && !clear_in);
    end
  end
endmodule

// [sfw_queue_ctrl.sv]
// Sample queue with watermark flag, overwrite or drop, flush and timestamp insertion.
module sfw_queue_ctrl #(
  parameter int STAGE_DEPTH = sfw_pkg::STAGE_DEPTH
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [sfw_pkg::TAG_W-1:0] sample_tag_in,
  input wire logic [sfw_pkg::VAL_W-1:0] sample_value_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic irq_n_out
);
  localparam int IW = sfw_pkg::IDX_W;
  localparam int CW = sfw_pkg::CNT_W;

  // Index and count widths are fixed for a 128-item store, and the timestamp phase wraps by itself at eight.
  generate
    if (STAGE_DEPTH < 2 || (1 << $clog2(STAGE_DEPTH)) != STAGE_DEPTH || sfw_pkg::QUEUE_DEPTH != (1 << IW) ||
        sfw_pkg::TS_PERIOD != (1 << sfw_pkg::PHASE_W))
    begin : g_bad_size
      $error("Queue controller sizes are out of range.");
    end
  endgenerate

  // One address compare for every strobe keeps the read and write maps in step.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  logic [sfw_pkg::ITEM_W-1:0] store [sfw_pkg::QUEUE_DEPTH];
  logic [IW-1:0] write_index;
  logic [IW-1:0] read_index;
  logic [CW-1:0] item_count;
  logic [IW-1:0] lost_item_count;
  logic [1:0] byte_sel;
  logic [7:0] irq_mask;
  logic [sfw_pkg::THR_W-1:0] afull_threshold;
  logic timestamp_en;
  logic clear_flags_on_data_read;
  logic afull_edge_type;
  logic overwrite_when_full;
  logic afull_seen;
  logic ts_pending;
  logic [sfw_pkg::PHASE_W-1:0] ts_phase;
  logic [sfw_pkg::VAL_W-1:0] sample_total;
  logic afull_flag;
  logic drdy_flag;

  // Register access decode.
  wire rd_flags = reg_read_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_FLAGS);
  wire rd_data = reg_read_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_DATA);
  wire wr_mask = reg_write_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_MASK);
  wire wr_rd_idx = reg_write_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_RD_IDX);
  wire wr_cfg1 = reg_write_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_CFG1);
  wire wr_cfg2 = reg_write_in && reg_hit(reg_addr_in, sfw_pkg::ADDR_CFG2);
  // The flush bit is never stored, so it always reads back as zero.
  wire flush_now = wr_cfg2 && reg_wdata_in[sfw_pkg::CFG2_FLUSH_BIT];

  // Staging buffer between the conversion sequencer and the main store.
  wire stage_valid;
  wire [sfw_pkg::ITEM_W-1:0] stage_item;
  // A pending timestamp takes the write slot, so the stage stalls for that cycle.
  wire stage_take = stage_valid && !ts_pending;

  sfw_stage_fifo #(
    .WIDTH(sfw_pkg::ITEM_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .clear_in(flush_now),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in({sample_tag_in, sample_value_in}),
    .out_valid_out(stage_valid),
    .out_ready_in(stage_take),
    .out_data_out(stage_item)
  );

  // Item offered to the store this cycle.
  wire push_req = (ts_pending || stage_valid) && !flush_now;
  wire [sfw_pkg::ITEM_W-1:0] push_item = ts_pending ? {sfw_pkg::TS_TAG, sample_total} : stage_item;

  // Host pops an item only on the third byte of a burst.
  // An empty queue still steps the byte counter, so bursts stay aligned after a late push.
  wire last_byte = byte_sel == sfw_pkg::LAST_BYTE;
  wire pop_now = rd_data && last_byte && item_count != '0 && !flush_now;
  wire full = item_count == sfw_pkg::COUNT_FULL;
  wire room = !full || pop_now;
  wire write_item = push_req && (room || overwrite_when_full);
  // Overwrite moves the read index past the oldest item, so a burst in progress may mix two items.
  wire discard_oldest = push_req && !room && overwrite_when_full;
  wire drop_item = push_req && !room && !overwrite_when_full;
  wire lose_item = discard_oldest || drop_item;
  wire count_up = write_item && !discard_oldest;
  wire [CW-1:0] next_item_count = item_count + CW'(count_up) - CW'(pop_now);

  // Watermark compare on the count that the push leaves behind.
  wire [CW-1:0] watermark = sfw_pkg::COUNT_FULL - CW'(afull_threshold);
  wire afull_cond = next_item_count >= watermark;
  wire afull_en = irq_mask[sfw_pkg::FLAG_AFULL_BIT];
  wire drdy_en = irq_mask[sfw_pkg::FLAG_DRDY_BIT];
  wire afull_level_set = !afull_edge_type && write_item && afull_cond;
  // The edge type re-arms only after the level drops below the mark, so a drain is needed for a second event.
  wire afull_edge_set = afull_edge_type && afull_cond && !afull_seen;
  wire set_afull = afull_en && (afull_level_set || afull_edge_set) && !flush_now;
  // Data-ready counts timestamps too, since the host must drain them like samples.
  wire set_drdy = drdy_en && write_item && !flush_now;
  wire data_read_clears = rd_data && clear_flags_on_data_read;
  wire clear_flags = rd_flags || data_read_clears;

  // Flush and the host clears share one input; a set wins over a host clear inside the cell, and both sets are masked during a flush.
  sfw_flag_cell u_afull (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .set_in(set_afull),
    .clear_in(clear_flags || flush_now),
    .flag_out(afull_flag)
  );

  sfw_flag_cell u_drdy (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .set_in(set_drdy),
    .clear_in(clear_flags || flush_now),
    .flag_out(drdy_flag)
  );

  wire [7:0] flags_value = {afull_flag, drdy_flag, 6'h00};
  wire [sfw_pkg::ITEM_W-1:0] head_item = store[read_index];
  wire [7:0] head_byte = byte_sel == 2'h0 ? head_item[23:16] : byte_sel == 2'h1 ? head_item[15:8] : head_item[7:0];
  wire [7:0] cfg2_value = {2'h0, timestamp_en, 1'b0, clear_flags_on_data_read, afull_edge_type,
                           overwrite_when_full, 1'b0};
  // Unmapped addresses read as zero.
  wire [7:0] read_mux =
    reg_addr_in == sfw_pkg::ADDR_FLAGS ? flags_value :
    reg_addr_in == sfw_pkg::ADDR_MASK ? irq_mask :
    reg_addr_in == sfw_pkg::ADDR_WR_IDX ? {1'b0, write_index} :
    reg_addr_in == sfw_pkg::ADDR_RD_IDX ? {1'b0, read_index} :
    reg_addr_in == sfw_pkg::ADDR_LOST ? {1'b0, lost_item_count} :
    reg_addr_in == sfw_pkg::ADDR_COUNT ? item_count :
    reg_addr_in == sfw_pkg::ADDR_DATA ? head_byte :
    reg_addr_in == sfw_pkg::ADDR_CFG1 ? {1'b0, afull_threshold} :
    reg_addr_in == sfw_pkg::ADDR_CFG2 ? cfg2_value : 8'h00;

  wire lost_at_max = lost_item_count == sfw_pkg::LOST_MAX;
  wire [IW-1:0] next_lost =
    pop_now ? '0 : (lose_item && !lost_at_max) ? lost_item_count + IW'(1) : lost_item_count;
  // Writing the read index lets the host re-read an item that has not yet been overwritten.
  wire [IW-1:0] next_read_index =
    wr_rd_idx ? reg_wdata_in[IW-1:0] : read_index + IW'(pop_now || discard_oldest);
  wire ts_due = timestamp_en && stage_take && ts_phase == sfw_pkg::PHASE_W'(sfw_pkg::TS_PERIOD - 1);

  always_ff @(posedge clock_in)
  begin
    if (write_item)
    begin
      store[write_index] <= push_item;
    end
  end

  // Host configuration registers.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_mask <= sfw_pkg::MASK_RST;
      afull_threshold <= sfw_pkg::THR_RST;
      timestamp_en <= 1'b0;
      clear_flags_on_data_read <= 1'b0;
      afull_edge_type <= 1'b0;
      overwrite_when_full <= 1'b0;
    end
    else
    begin
      if (wr_mask)
      begin
        irq_mask <= {reg_wdata_in[sfw_pkg::FLAG_AFULL_BIT:sfw_pkg::FLAG_DRDY_BIT], 6'h00};
      end
      if (wr_cfg1)
      begin
        afull_threshold <= reg_wdata_in[sfw_pkg::THR_W-1:0];
      end
      if (wr_cfg2)
      begin
        timestamp_en <= reg_wdata_in[sfw_pkg::CFG2_TS_BIT];
        clear_flags_on_data_read <= reg_wdata_in[sfw_pkg::CFG2_STATCLR_BIT];
        afull_edge_type <= reg_wdata_in[sfw_pkg::CFG2_TYPE_BIT];
        overwrite_when_full <= reg_wdata_in[sfw_pkg::CFG2_OVERWRITE_BIT];
      end
    end
  end

  // Read data is held until the next read, so a slow serial front end may fetch it late.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= reg_read_in ? read_mux : reg_rdata_out;
      reg_rvalid_out <= reg_read_in;
    end
  end

  // The pin is a flop so that it never glitches while both flags change.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_n_out <= 1'b1;
    end
    else
    begin
      irq_n_out <= !(afull_flag || drdy_flag);
    end
  end

  // Queue indexes and counts.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      write_index <= '0;
      read_index <= '0;
      item_count <= '0;
      lost_item_count <= '0;
      byte_sel <= 2'h0;
      afull_seen <= 1'b0;
    end
    else if (flush_now)
    begin
      write_index <= '0;
      read_index <= '0;
      item_count <= '0;
      lost_item_count <= '0;
      byte_sel <= 2'h0;
      afull_seen <= 1'b0;
    end
    else
    begin
      write_index <= write_index + IW'(write_item);
      read_index <= next_read_index;
      item_count <= next_item_count;
      lost_item_count <= next_lost;
      // A rewritten read index restarts the byte burst at the top byte.
      byte_sel <= wr_rd_idx ? 2'h0 : rd_data ? (last_byte ? 2'h0 : byte_sel + 2'h1) : byte_sel;
      afull_seen <= afull_cond;
    end
  end

  // Timestamp scheduling; the phase only runs while insertion is enabled.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ts_pending <= 1'b0;
      ts_phase <= '0;
      sample_total <= '0;
    end
    else if (flush_now)
    begin
      ts_pending <= 1'b0;
      ts_phase <= '0;
      sample_total <= '0;
    end
    else
    begin
      // The total wraps at nineteen bits; only its low bits matter for aligning two streams.
      sample_total <= sample_total + sfw_pkg::VAL_W'(stage_take);
      // A timestamp that meets a full store without overwrite is lost and counted like a sample.
      ts_pending <= ts_due;
      ts_phase <= !timestamp_en ? '0 : ts_phase + sfw_pkg::PHASE_W'(stage_take);
    end
  end
endmodule

// [sfw_queue_ctrl_chk.sv]
// Port-level assertions for the sample queue controller.
module sfw_queue_ctrl_chk (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sample_valid_in,
  input wire logic sample_ready_out,
  input wire logic [4:0] sample_tag_in,
  input wire logic [18:0] sample_value_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic irq_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  read_answer_a: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  no_stray_a: assert property (!reg_read_in |=> !reg_rvalid_out)
    else $error("answer without read");
  rdata_hold_a: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  thr_field_a: assert property (reg_read_in && reg_addr_in == 8'h09 |=> !reg_rdata_out[7])
    else $error("threshold wider than seven bits");
  flush_self_a: assert property (reg_read_in && reg_addr_in == 8'h0a |=> !reg_rdata_out[4])
    else $error("flush bit stuck");
  count_bound_a: assert property (reg_read_in && reg_addr_in == 8'h07 |=> reg_rdata_out <= 8'h80)
    else $error("count above depth");
  lost_width_a: assert property (reg_read_in && reg_addr_in == 8'h06 |=> !reg_rdata_out[7])
    else $error("lost count too wide");
  flush_empty_a: assert property (reg_write_in && reg_addr_in == 8'h0a && reg_wdata_in[4]
    ##2 reg_read_in && reg_addr_in == 8'h07 |=> reg_rdata_out == 8'h00) else $error("flush left items");
endmodule
bind sfw_queue_ctrl sfw_queue_ctrl_chk sfw_queue_ctrl_chk_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out), .sample_tag_in(sample_tag_in),
  .sample_value_in(sample_value_in), .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .irq_n_out(irq_n_out));

// [sfw_host.sv]
// Host model issuing one-cycle register strobes.
module sfw_host (
  input wire logic clock_in,
  output logic [7:0] addr_out,
  output logic write_out,
  output logic read_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr_out = 8'h01;
    write_out = 1'b0;
    read_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Released address and data lines show inverted values so a stale address is never mistaken for a live one.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_in);
    addr_out = a;
    wdata_out = d;
    write_out = wr;
    read_out = !wr;
    @(negedge clock_in);
    q = rdata_in;
    write_out = 1'b0;
    read_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the sample queue controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic valid = 1'b0;
  logic [4:0] tag = 5'h00;
  logic [18:0] val = 19'h00000;
  logic ready, rvalid, irq_n, wr, rd;
  logic [7:0] addr, wdata, rdata, q;
  logic [23:0] exp_q[$];
  logic [31:0] seed = 32'd88350;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clock_in = ~clock_in;
  sfw_queue_ctrl sfw_queue_ctrl_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .sample_valid_in(valid),
    .sample_ready_out(ready), .sample_tag_in(tag), .sample_value_in(val), .reg_addr_in(addr),
    .reg_write_in(wr), .reg_read_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .irq_n_out(irq_n));
  sfw_host sfw_host_i (.clock_in(clock_in), .addr_out(addr), .write_out(wr), .read_out(rd),
    .wdata_out(wdata), .rdata_in(rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int wm(input int thr);
    return sfw_pkg::QUEUE_DEPTH - thr;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    sfw_host_i.access(1'b1, a, d, q);
    chk({7'h00, rvalid}, 8'h00);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    sfw_host_i.access(1'b0, a, 8'h00, q);
    chk(q, e);
    chk({7'h00, rvalid}, 8'h01);
  endtask
  task automatic push(input int n);
    repeat (n)
    begin
      @(negedge clock_in);
      seed = lfsr(seed);
      valid = 1'b1;
      tag = seed[28:24];
      val = seed[18:0];
      exp_q.push_back({tag, val});
      while (ready !== 1'b1)
        @(negedge clock_in);
    end
    @(negedge clock_in);
    valid = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask
  task automatic item();
    logic [23:0] e;
    e = exp_q.pop_front();
    rchk(8'h08, e[23:16]);
    rchk(8'h08, e[15:8]);
    rchk(8'h08, e[7:0]);
  endtask
  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    repeat (6) @(negedge clock_in);
    reset_n_in = 1'b1;
    rchk(8'h03, 8'h00);
    rchk(8'h09, 8'h00);
    rchk(8'h01, 8'h00);
    wreg(8'h09, 8'hfc);
    rchk(8'h09, 8'h7c);
    wreg(8'h03, 8'hc0);
    push(wm(124) - 1);
    rchk(8'h00, 8'h40);
    push(1);
    chk({7'h00, irq_n}, 8'h00);
    rchk(8'h00, 8'hc0);
    rchk(8'h00, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    push(1);
    rchk(8'h07, 8'h05);
    item();
    rchk(8'h00, 8'hc0);
    wreg(8'h0a, 8'h08);
    push(1);
    item();
    rchk(8'h00, 8'h00);
    repeat (4) item();
    rchk(8'h07, 8'h00);
    wreg(8'h0a, 8'h04);
    push(4);
    rchk(8'h00, 8'hc0);
    push(1);
    rchk(8'h00, 8'h40);
    wreg(8'h0a, 8'h14);
    rchk(8'h07, 8'h00);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h0a, 8'h04);
    exp_q.delete();
    wreg(8'h09, 8'h00);
    wreg(8'h0a, 8'h00);
    push(130);
    while (exp_q.size() > sfw_pkg::QUEUE_DEPTH)
      void'(exp_q.pop_back());
    rchk(8'h07, 8'h80);
    rchk(8'h06, 8'h02);
    item();
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h7f);
    wreg(8'h0a, 8'h10);
    exp_q.delete();
    wreg(8'h0a, 8'h02);
    push(130);
    rchk(8'h07, 8'h80);
    while (exp_q.size() > sfw_pkg::QUEUE_DEPTH)
      void'(exp_q.pop_front());
    item();
    wreg(8'h0a, 8'h30);
    exp_q.delete();
    push(8);
    exp_q.push_back({5'h1e, 19'h00008});
    rchk(8'h07, 8'h09);
    repeat (9) item();
    wreg(8'h05, 8'h08);
    rchk(8'h05, 8'h08);
    rchk(8'h08, 8'hf0);
    rchk(8'h08, 8'h00);
    rchk(8'h08, 8'h08);
    rchk(8'h07, 8'h00);
    rchk(8'h05, 8'h08);
    wreg(8'h0a, 8'h00);
    push(8);
    rchk(8'h07, 8'h08);
    close_out();
  end
endmodule
